// ==== rtl/sfrl_pkg.sv ====
package sfrl_pkg;

   // Status word field positions
   localparam int STOP_EN_POS = 15;
   localparam int MAC_TOP_OVF_POS = 14;
   localparam int HALF_CARRY_POS = 13;
   localparam int MAC_EXT_OVF_POS = 12;
   localparam int NEG_POS = 11;
   localparam int ZERO_POS = 10;
   localparam int OVF_POS = 9;
   localparam int CARRY_POS = 8;
   localparam int IRQ_MASK_HI = 7;
   localparam int IRQ_MASK_LO = 5;
   localparam int SATURATE_POS = 4;
   localparam int FETCH_EXT_HI = 3;
   localparam int FETCH_EXT_LO = 0;

   // Stop enable set, interrupt mask at 7: every level masked except the top level 7, which is always taken
   localparam logic [15:0] PSW_RESET = 16'h80e0;

   localparam logic [2:0] IRQ_TOP_LEVEL = 3'h7;
   localparam logic [15:0] SAT_MAX_POS = 16'h7fff;
   localparam logic [15:0] SAT_MAX_NEG = 16'h8000;
   localparam int MAC_SIGN_POS = 35;
   localparam int MAC_EXT_POS = 31;

   typedef struct packed {
      logic [15:0] psw;
      logic sat_sign;
      logic halt;
      logic nop;
      logic irq_take;
      logic [19:0] fetch;
   } sfrl_core_s;

   typedef struct packed {
      logic [15:0] data;
      logic valid;
   } sfrl_read_s;

   // Signed overflow from the sign bits of both operands and the result
   function automatic logic sfrl_sign_ovf(input logic sa, input logic sb, input logic sr);
      sfrl_sign_ovf = (sa == sb) && (sr != sa);
   endfunction : sfrl_sign_ovf

   // Most significant bit of a byte or word operand
   function automatic logic sfrl_msb(input logic [15:0] x, input logic byte_op);
      sfrl_msb = byte_op ? x[7] : x[15];
   endfunction : sfrl_msb

endpackage : sfrl_pkg

// ==== rtl/sfrl_mac_read.sv ====
`timescale 1ns/100ps
module sfrl_mac_read
   import sfrl_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic rd_en_in,
   input wire logic round_in,
   input wire logic [35:0] acc_in,
   input wire logic sat_en_in,
   input wire logic sat_sign_in,
   output logic [15:0] rd_data_out,
   output logic rd_valid_out
);

   sfrl_read_s q;
   sfrl_read_s next_q;

   always_comb begin
      next_q = q;
      next_q.valid = rd_en_in;
      if (rd_en_in) begin
         if (sat_en_in) begin
            next_q.data = sat_sign_in ? SAT_MAX_NEG : SAT_MAX_POS;
         end else if (round_in) begin
            // Rounding wrap at the top is not clamped here
            next_q.data = acc_in[31:16] + {15'h0000, acc_in[15]};
         end else begin
            next_q.data = acc_in[31:16];
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign rd_data_out = q.data;
   assign rd_valid_out = q.valid;

endmodule : sfrl_mac_read

// ==== rtl/sfrl_core.sv ====
`timescale 1ns/100ps
module sfrl_core
   import sfrl_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic psw_wr_en_in,
   input wire logic [15:0] psw_wr_data_in,
   input wire logic alu_byte_in,
   input wire logic alu_sub_in,
   input wire logic [15:0] alu_opa_in,
   input wire logic [15:0] alu_opb_in,
   input wire logic [15:0] alu_result_in,
   input wire logic alu_carry_in,
   input wire logic upd_nz_in,
   input wire logic upd_v_in,
   input wire logic upd_c_in,
   input wire logic upd_h_in,
   input wire logic mac_upd_in,
   input wire logic [35:0] mac_acc_old_in,
   input wire logic [35:0] mac_addend_in,
   input wire logic [35:0] mac_acc_in,
   input wire logic mac_read_rounded_instr_in,
   input wire logic mac_read_truncated_instr_in,
   input wire logic low_power_halt_instr_in,
   input wire logic wake_in,
   input wire logic irq_valid_in,
   input wire logic [2:0] irq_level_in,
   input wire logic [15:0] pc_in,
   output logic [15:0] processor_status_word_out,
   output logic halt_clocks_out,
   output logic halt_nop_out,
   output logic irq_take_out,
   output logic [19:0] fetch_addr_out,
   output logic [15:0] mac_rd_data_out,
   output logic mac_rd_valid_out
);

   sfrl_core_s q;
   sfrl_core_s next_q;
   logic [35:0] mac_sum;
   logic mac_top_ovf;
   logic mac_ext_ovf;
   logic [4:0] nibble_sum;
   logic sat_active;

   assign mac_sum = mac_acc_old_in + mac_addend_in;
   assign mac_top_ovf = sfrl_sign_ovf(mac_acc_old_in[MAC_SIGN_POS],
                                      mac_addend_in[MAC_SIGN_POS], mac_sum[MAC_SIGN_POS]);
   assign mac_ext_ovf = (mac_sum[35:MAC_EXT_POS] != 5'h00) && (mac_sum[35:MAC_EXT_POS] != 5'h1f);
   assign nibble_sum = {1'b0, alu_opa_in[3:0]} + {1'b0, alu_opb_in[3:0]};
   assign sat_active = q.psw[SATURATE_POS] && (q.psw[MAC_TOP_OVF_POS] || q.psw[MAC_EXT_OVF_POS]);

   always_comb begin
      logic sb;
      sb = 1'b0;
      next_q = q;
      next_q.nop = 1'b0;
      if (psw_wr_en_in) begin
         next_q.psw = psw_wr_data_in;
      end else begin
         if (upd_nz_in) begin
            next_q.psw[NEG_POS] = sfrl_msb(alu_result_in, alu_byte_in);
            next_q.psw[ZERO_POS] = alu_byte_in ? (alu_result_in[7:0] == 8'h00)
                                               : (alu_result_in == 16'h0000);
         end
         if (upd_v_in) begin
            sb = sfrl_msb(alu_opb_in, alu_byte_in) ^ alu_sub_in;
            next_q.psw[OVF_POS] = sfrl_sign_ovf(sfrl_msb(alu_opa_in, alu_byte_in), sb,
                                                sfrl_msb(alu_result_in, alu_byte_in));
         end
         if (upd_c_in) begin
            next_q.psw[CARRY_POS] = alu_carry_in;
         end
         if (upd_h_in) begin
            next_q.psw[HALF_CARRY_POS] = nibble_sum[4];
         end
      end
      // MAC overflow sets win over a load clearing them
      if (mac_upd_in) begin
         if (!q.psw[MAC_TOP_OVF_POS] && !q.psw[MAC_EXT_OVF_POS] && (mac_top_ovf || mac_ext_ovf)) begin
            next_q.sat_sign = mac_acc_old_in[MAC_SIGN_POS];
         end
         if (mac_top_ovf) begin
            next_q.psw[MAC_TOP_OVF_POS] = 1'b1;
         end
         if (mac_ext_ovf) begin
            next_q.psw[MAC_EXT_OVF_POS] = 1'b1;
         end
      end
      if (low_power_halt_instr_in && !q.halt) begin
         if (q.psw[STOP_EN_POS]) begin
            next_q.nop = 1'b1;
         end else begin
            next_q.halt = 1'b1;
         end
      end else if (wake_in) begin
         next_q.halt = 1'b0;
      end
      next_q.irq_take = irq_valid_in && ((irq_level_in > q.psw[IRQ_MASK_HI:IRQ_MASK_LO])
                                         || (irq_level_in == IRQ_TOP_LEVEL));
      next_q.fetch = {q.psw[FETCH_EXT_HI:FETCH_EXT_LO], pc_in};
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         q.psw <= PSW_RESET;
         q.sat_sign <= 1'b0;
         q.halt <= 1'b0;
         q.nop <= 1'b0;
         q.irq_take <= 1'b0;
         q.fetch <= 20'h00000;
      end else begin
         q <= next_q;
      end
   end

   sfrl_mac_read u_mac_read (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .rd_en_in(mac_read_rounded_instr_in || mac_read_truncated_instr_in),
      .round_in(mac_read_rounded_instr_in),
      .acc_in(mac_acc_in),
      .sat_en_in(sat_active),
      .sat_sign_in(q.sat_sign),
      .rd_data_out(mac_rd_data_out),
      .rd_valid_out(mac_rd_valid_out)
   );

   assign processor_status_word_out = q.psw;
   assign halt_clocks_out = q.halt;
   assign halt_nop_out = q.nop;
   assign irq_take_out = q.irq_take;
   assign fetch_addr_out = q.fetch;

endmodule : sfrl_core

// ==== verification/sfrl_core_props.sv ====
`timescale 1ns/100ps
module sfrl_core_props (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic psw_wr_en_in,
   input wire logic [15:0] psw_wr_data_in,
   input wire logic mac_upd_in,
   input wire logic mac_read_rounded_instr_in,
   input wire logic mac_read_truncated_instr_in,
   input wire logic low_power_halt_instr_in,
   input wire logic irq_valid_in,
   input wire logic [2:0] irq_level_in,
   input wire logic [15:0] pc_in,
   input wire logic [15:0] processor_status_word_out,
   input wire logic halt_clocks_out,
   input wire logic halt_nop_out,
   input wire logic irq_take_out,
   input wire logic [19:0] fetch_addr_out,
   input wire logic mac_rd_valid_out
);
   wire [15:0] psw = processor_status_word_out;
   wire stp = low_power_halt_instr_in && !halt_clocks_out;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   sequence s_pulse; halt_nop_out ##1 !halt_nop_out; endsequence
   property p_load; psw_wr_en_in && !mac_upd_in |=> psw == $past(psw_wr_data_in); endproperty
   property p_sticky; psw[14] && !psw_wr_en_in |=> psw[14]; endproperty
   property p_stop; stp && !psw[15] |=> halt_clocks_out; endproperty
   // Second instruction right behind would stretch the pulse
   property p_nop; stp && psw[15] ##1 !low_power_halt_instr_in |-> s_pulse; endproperty
   property p_top; irq_valid_in && irq_level_in == 3'h7 |=> irq_take_out; endproperty
   property p_mask; irq_valid_in && irq_level_in != 3'h7 && irq_level_in <= psw[7:5]
      |=> !irq_take_out; endproperty
   property p_fetch; 1'b1 |=> fetch_addr_out == {$past(psw[3:0]), $past(pc_in)}; endproperty
   property p_read; mac_read_rounded_instr_in || mac_read_truncated_instr_in
      |=> mac_rd_valid_out; endproperty
   a_load: assert property (p_load) else $error("load lost");
   a_sticky: assert property (p_sticky) else $error("mac flag dropped");
   a_stop: assert property (p_stop) else $error("no halt");
   a_nop: assert property (p_nop) else $error("no nop pulse");
   a_top: assert property (p_top) else $error("top level lost");
   a_mask: assert property (p_mask) else $error("mask leak");
   a_fetch: assert property (p_fetch) else $error("fetch address");
   a_read: assert property (p_read) else $error("no read valid");
endmodule : sfrl_core_props
bind sfrl_core sfrl_core_props u_props (.*);

// ==== verification/sfrl_tb.sv ====
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_compared++; if ((e) !== (a)) begin failures++; \
   $display("[ERR] %s exp %h got %h", n, e, a); end end
module testbench;
   localparam logic [10:0] WR = 11'h400, NZ = 11'h200, VF = 11'h100, CF = 11'h080;
   localparam logic [10:0] HF = 11'h040, MC = 11'h020, RND = 11'h010, TRN = 11'h008;
   localparam logic [10:0] HLT = 11'h004, WK = 11'h002, IRQ = 11'h001;
   localparam logic [18:0] NZT [4] = '{19'h20000, 19'h48000, 19'h50180, 19'h3ff00};
   logic clk_sys_in = 0, resetn_in = 0, alu_byte_in = 0, alu_carry_in = 0, alu_sub_in = 0;
   logic halt, nop, take, valid;
   logic [10:0] p = '0;
   logic [15:0] wd = '0, opa = '0, opb = '0, res = '0, pc = '0, psw, mdata;
   logic [35:0] aold = '0, aadd = '0, acc = '0;
   logic [2:0] lvl = '0;
   logic [19:0] fetch;
   logic [21:0] e;
   logic [21:0] exp_q [$];
   int failures = 0, n_compared = 0, seed = 53401;
   always #25 clk_sys_in = ~clk_sys_in;
   sfrl_core uut (.clk_sys_in, .resetn_in, .psw_wr_en_in(p[10]), .psw_wr_data_in(wd),
      .alu_byte_in, .alu_sub_in, .alu_opa_in(opa), .alu_opb_in(opb), .alu_result_in(res),
      .alu_carry_in, .upd_nz_in(p[9]), .upd_v_in(p[8]), .upd_c_in(p[7]), .upd_h_in(p[6]),
      .mac_upd_in(p[5]), .mac_acc_old_in(aold), .mac_addend_in(aadd), .mac_acc_in(acc),
      .mac_read_rounded_instr_in(p[4]), .mac_read_truncated_instr_in(p[3]),
      .low_power_halt_instr_in(p[2]), .wake_in(p[1]), .irq_valid_in(p[0]),
      .irq_level_in(lvl), .pc_in(pc), .processor_status_word_out(psw), .halt_clocks_out(halt),
      .halt_nop_out(nop), .irq_take_out(take), .fetch_addr_out(fetch),
      .mac_rd_data_out(mdata), .mac_rd_valid_out(valid));
   // Request and its data change together, held through one rising edge
   task automatic step(input logic [10:0] pv);
      p = pv;
      @(negedge clk_sys_in);
   endtask : step
   task automatic note(input logic [1:0] s, input logic [19:0] v);
      exp_q.push_back({s, v});
   endtask : note
   task automatic ld(input logic [15:0] v);
      wd = v;
      step(WR);
      note(2'h0, 20'(v));
   endtask : ld
   task automatic end_sim;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   // Results of the taking edge, looked at the falling edge after it
   always @(negedge clk_sys_in) begin
      #1;
      while (exp_q.size() > 0) begin
         e = exp_q.pop_front();
         case (e[21:20])
            2'h0: `CHK("psw", e[15:0], psw)
            2'h1: `CHK("flags", e[3:0], {halt, nop, take, valid})
            2'h2: `CHK("fetch", e[19:0], fetch)
            default: `CHK("mac_data", e[15:0], mdata)
         endcase
      end
   end
   initial begin
      #1ms;
      failures++;
      end_sim();
   end
   initial begin
      repeat (10) @(negedge clk_sys_in);
      resetn_in = 1;
      note(2'h0, 20'h080e0);
      note(2'h1, 20'h0);
      pc = 16'($random(seed));
      ld(16'($random(seed)));
      step(11'h0);
      note(2'h2, {wd[3:0], pc});
      ld(16'h0000);
      for (int i = 0; i < 4; i++) begin
         {alu_byte_in, res} = NZT[i][16:0];
         step(NZ);
         note(2'h0, 20'({NZT[i][18:17], 10'h000}));
      end
      {alu_byte_in, alu_sub_in, opa, opb, res} = {2'b01, 16'h7fff, 16'hffff, 16'h8000};
      step(VF);
      note(2'h0, 20'h00600);
      {alu_sub_in, opa, opb, res, alu_carry_in} = {1'b0, 16'h7fff, 16'h0001, 16'h8000, 1'b1};
      step(VF | CF);
      note(2'h0, 20'h00700);
      {opa, opb, alu_carry_in} = {16'h000f, 16'h0001, 1'b0};
      step(HF);
      note(2'h0, 20'h02700);
      step(CF);
      note(2'h0, 20'h02600);
      {aold, aadd} = {36'h7_ffff_ffff, 36'h1};
      step(MC);
      note(2'h0, 20'h07600);
      $display("flag test done");
      ld(16'h0010);
      step(MC);
      note(2'h0, 20'h05010);
      step(TRN);
      note(2'h3, 20'h07fff);
      note(2'h1, 20'h1);
      ld(16'h0010);
      {aold, aadd} = {36'hf_8000_0000, 36'hf_ffff_ffff};
      step(MC);
      note(2'h0, 20'h01010);
      step(TRN);
      note(2'h3, 20'h08000);
      ld(16'h0000);
      acc = 36'h1_2345_8789;
      step(TRN);
      note(2'h3, 20'h02345);
      step(RND);
      note(2'h3, 20'h02346);
      $display("mac test done");
      step(HLT);
      note(2'h1, 20'h8);
      step(11'h0);
      step(WK);
      note(2'h1, 20'h0);
      ld(16'h8000);
      step(HLT);
      note(2'h1, 20'h4);
      step(11'h0);
      note(2'h1, 20'h0);
      ld(16'h0060);
      for (int i = 0; i < 8; i++) begin
         lvl = 3'(i);
         step(IRQ);
         note(2'h1, 20'(i > 3) << 1);
      end
      step(11'h0);
      step(11'h0);
      $display("control test done");
      end_sim();
   end
endmodule : testbench
